// File: pkg/nibble_link_if.sv
// Interface carrying the eight wires of the simplified nibble link.
`timescale 1ns/100ps
interface nibble_link_if;
    logic link_clk;
    logic frame_n;
    logic [4:0] m_bus_out;
    logic m_bus_oe;
    logic [4:0] s_bus_out;
    logic s_bus_oe;
    logic irq_n;
    logic [4:0] bus_in;
    // Resolve the shared bus; pull-ups hold it high when released.
    assign bus_in = m_bus_oe ? m_bus_out : (s_bus_oe ? s_bus_out : 5'h1f);
    modport master (output link_clk, output frame_n, output m_bus_out,
        output m_bus_oe, input bus_in, input irq_n);
    modport slave (input link_clk, input frame_n, output s_bus_out,
        output s_bus_oe, input bus_in, output irq_n);
endinterface

// File: pkg/nibble_link_pkg.sv
// Types shared by both ends of the simplified nibble link.
package nibble_link_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0, ST_TYPE = 4'h1, ST_ADDR = 4'h3, ST_WDATA = 4'h2,
        ST_MTAR = 4'h6, ST_SYNC = 4'h7, ST_RDATA = 4'h5, ST_STAR = 4'h4,
        ST_START = 4'hc
    } link_state_t;
endpackage

// File: pkg/nibble_link_regs.svh
// Timing counts and link encodings for the simplified nibble link.
`ifndef NIBBLE_LINK_REGS_SVH
`define NIBBLE_LINK_REGS_SVH
// Summary of operation
// - Link is clock, frame, five-bit bus, interrupt.
// - Bit four carries parity of nibble bits.
// - Frame low only in the start cycle.
// - Start cycle carries nibble 0000.
// - Type 0100 means memory read.
// - Type 0110 means memory write.
// - Four address nibbles, most significant first.
// - Four data nibbles, least significant first.
// - Turnaround: ones, then released, two cycles.
// - Sync: 0101 waits, 0000 in last cycle.
// - Read sequence takes at most 18 cycles.
// - Write sequence takes at most 18 cycles.
// - Only memory read and write supported.
// - Sixteen-bit address, 64KB space.
// - Sixteen data bits per transfer.
// - Master splits 32-bit access into two.
// - Undriven cycles released, pulled high.
// - Slave asserts active-low interrupt when pending.
`define NL_NIB_START 4'h0
`define NL_NIB_READ 4'h4
`define NL_NIB_WRITE 4'h6
`define NL_NIB_TAR 4'hf
`define NL_NIB_WAIT 4'h5
`define NL_NIB_READY 4'h0
`define NL_SYNC_CYCLES 3'h4
`define NL_ADDR_STEP 16'h0002
`define NL_CLK_DIV 8'h05
`endif

// File: rtl/nibble_link_master.sv
// Host end of the simplified nibble link; splits 32-bit user accesses.
`timescale 1ns/100ps
`include "nibble_link_regs.svh"
module nibble_link_master
    import nibble_link_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    nibble_link_if.master link,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_we,
    input wire logic [15:0] req_addr,
    input wire logic [31:0] req_wdata,
    output logic done,
    output logic [31:0] rdata,
    output logic irq,
    output logic parity_err
);
    link_state_t st_q, st_d;
    logic [2:0] cnt_q, cnt_d;
    logic half_q, half_d;
    logic [15:0] addr_q, addr_d;
    logic [31:0] data_q, data_d;
    logic we_q, we_d, done_q, done_d, perr_q, perr_d;
    logic [7:0] div_q, div_d;
    logic lclk_q, lclk_d, tick;
    logic irq_s1_q, irq_s2_q;
    logic [15:0] cur_addr;
    logic [15:0] cur_data;

    // Link clock divider; the sequencer advances on each falling link edge,
    // half a link cycle away from the rising edge at which the slave samples.
    assign tick = (div_q == `NL_CLK_DIV) && lclk_q;
    always_comb
    begin
        div_d = div_q + 8'h01;
        lclk_d = lclk_q;
        if (div_q == `NL_CLK_DIV)
        begin
            div_d = 8'h00;
            lclk_d = !lclk_q;
        end
    end

    // Current half: lower half at even address, then upper at plus two.
    assign cur_addr = half_q ? (addr_q + `NL_ADDR_STEP) : addr_q;
    assign cur_data = half_q ? data_q[31:16] : data_q[15:0];

    // Sequencer next state; each step occupies one link clock.
    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        half_d = half_q;
        addr_d = addr_q;
        data_d = data_q;
        we_d = we_q;
        done_d = 1'b0;
        perr_d = perr_q;
        if (req_valid && req_ready)
        begin
            addr_d = {req_addr[15:2], 2'b00};
            data_d = req_wdata;
            we_d = req_we;
            half_d = 1'b0;
            perr_d = 1'b0;
            st_d = ST_START;
        end
        else if (tick)
        begin
            cnt_d = cnt_q + 3'h1;
            unique case (st_q)
                ST_IDLE: cnt_d = 3'h0;
                ST_START: begin st_d = ST_TYPE; cnt_d = 3'h0; end
                ST_TYPE: begin st_d = ST_ADDR; cnt_d = 3'h0; end
                ST_ADDR:
                    if (cnt_q == 3'h3)
                    begin
                        cnt_d = 3'h0;
                        st_d = we_q ? ST_WDATA : ST_MTAR;
                    end
                ST_WDATA:
                    if (cnt_q == 3'h3) begin cnt_d = 3'h0; st_d = ST_MTAR; end
                ST_MTAR:
                    if (cnt_q == 3'h1) begin cnt_d = 3'h0; st_d = ST_SYNC; end
                ST_SYNC:
                begin
                    if (link.bus_in[3:0] == `NL_NIB_READY)
                    begin
                        cnt_d = 3'h0;
                        st_d = we_q ? ST_STAR : ST_RDATA;
                    end
                    if ((^link.bus_in) != 1'b0)
                        perr_d = 1'b1;
                end
                ST_RDATA:
                begin
                    if (half_q)
                        data_d[31:16] = {link.bus_in[3:0], data_q[31:20]};
                    else
                        data_d[15:0] = {link.bus_in[3:0], data_q[15:4]};
                    if ((^link.bus_in) != 1'b0)
                        perr_d = 1'b1;
                    if (cnt_q == 3'h3) begin cnt_d = 3'h0; st_d = ST_STAR; end
                end
                ST_STAR:
                    if (cnt_q == 3'h1)
                    begin
                        cnt_d = 3'h0;
                        half_d = 1'b1;
                        st_d = half_q ? ST_IDLE : ST_START;
                        done_d = half_q;
                    end
                default: st_d = ST_IDLE;
            endcase
        end
    end

    // Registers of the host domain.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_q <= ST_IDLE;
            cnt_q <= 3'h0;
            half_q <= 1'b0;
            addr_q <= 16'h0000;
            data_q <= 32'h00000000;
            we_q <= 1'b0;
            done_q <= 1'b0;
            perr_q <= 1'b0;
            div_q <= 8'h00;
            lclk_q <= 1'b0;
            irq_s1_q <= 1'b0;
            irq_s2_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            half_q <= half_d;
            addr_q <= addr_d;
            data_q <= data_d;
            we_q <= we_d;
            done_q <= done_d;
            perr_q <= perr_d;
            div_q <= div_d;
            lclk_q <= lclk_d;
            irq_s1_q <= !link.irq_n;
            irq_s2_q <= irq_s1_q;
        end
    end

    // Master bus drive: start, type, address, write data, first turnaround.
    always_comb
    begin
        link.m_bus_oe = 1'b0;
        link.m_bus_out = 5'h1f;
        unique case (st_q)
            ST_START:
            begin
                link.m_bus_oe = 1'b1;
                link.m_bus_out[3:0] = `NL_NIB_START;
            end
            ST_TYPE:
            begin
                link.m_bus_oe = 1'b1;
                link.m_bus_out[3:0] = we_q ? `NL_NIB_WRITE : `NL_NIB_READ;
            end
            ST_ADDR:
            begin
                link.m_bus_oe = 1'b1;
                link.m_bus_out[3:0] = cur_addr[4'(4'hc - {cnt_q[1:0], 2'b00}) +: 4];
            end
            ST_WDATA:
            begin
                link.m_bus_oe = 1'b1;
                link.m_bus_out[3:0] = cur_data[{cnt_q[1:0], 2'b00} +: 4];
            end
            ST_MTAR:
            begin
                link.m_bus_oe = (cnt_q == 3'h0);
                link.m_bus_out[3:0] = `NL_NIB_TAR;
            end
            default: link.m_bus_oe = 1'b0;
        endcase
        link.m_bus_out[4] = ^link.m_bus_out[3:0];
    end

    assign link.link_clk = lclk_q;
    assign link.frame_n = (st_q != ST_START);
    // A request is taken only on a link step, so the start cycle is whole.
    assign req_ready = (st_q == ST_IDLE) && tick;
    assign done = done_q;
    assign rdata = data_q;
    assign irq = irq_s2_q;
    assign parity_err = perr_q;
endmodule

// File: rtl/nibble_link_slave.sv
// Device end of the simplified nibble link, memory side on the link clock.
`timescale 1ns/100ps
`include "nibble_link_regs.svh"
module nibble_link_slave
    import nibble_link_pkg::*;
#(
    parameter int WAIT_CYCLES = 0
)(
    nibble_link_if.slave link,
    input wire logic rst,
    output logic mem_req,
    output logic mem_we,
    output logic [15:0] mem_addr,
    output logic [15:0] mem_wdata,
    input wire logic [15:0] mem_rdata,
    input wire logic irq_pending,
    output logic parity_err
);
    // Sequencer state, shift registers and the parity flag.
    link_state_t st_q, st_d;
    logic [2:0] cnt_q, cnt_d;
    logic we_q, we_d;
    logic [15:0] addr_q, addr_d;
    logic [15:0] data_q, data_d;
    logic perr_q, perr_d;
    logic [3:0] nib;
    logic par_ok;

    //----------------------------------------------------------------
    // Link receive and sequencing
    //----------------------------------------------------------------

    // Incoming nibble and its even-parity check. The master changes the
    // bus on the falling link edge, so it is settled at every rising edge.
    assign nib = link.bus_in[3:0];
    assign par_ok = (^link.bus_in) == 1'b0;

    // Next-state logic of the slave sequencer. A start pattern wins over
    // every state, so a frame that the master cuts short cannot hang the
    // slave; it simply waits for the next start.
    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        we_d = we_q;
        addr_d = addr_q;
        data_d = data_q;
        perr_d = 1'b0;
        if (!link.frame_n && nib == `NL_NIB_START)
        begin
            st_d = ST_TYPE;
            perr_d = !par_ok;
        end
        else
        begin
            unique case (st_q)
                ST_IDLE, ST_START: st_d = ST_IDLE;
                ST_TYPE:
                begin
                    perr_d = !par_ok;
                    cnt_d = 3'h0;
                    if (nib == `NL_NIB_READ)
                    begin
                        we_d = 1'b0;
                        st_d = ST_ADDR;
                    end
                    else if (nib == `NL_NIB_WRITE)
                    begin
                        we_d = 1'b1;
                        st_d = ST_ADDR;
                    end
                    else
                        st_d = ST_IDLE;
                end
                ST_ADDR:
                begin
                    perr_d = !par_ok;
                    addr_d = {addr_q[11:0], nib};
                    cnt_d = cnt_q + 3'h1;
                    if (cnt_q == 3'h3)
                    begin
                        cnt_d = 3'h0;
                        st_d = we_q ? ST_WDATA : ST_MTAR;
                    end
                end
                ST_WDATA:
                begin
                    perr_d = !par_ok;
                    data_d = {nib, data_q[15:4]};
                    cnt_d = cnt_q + 3'h1;
                    if (cnt_q == 3'h3)
                    begin
                        cnt_d = 3'h0;
                        st_d = ST_MTAR;
                    end
                end
                ST_MTAR:
                begin
                    cnt_d = cnt_q + 3'h1;
                    if (cnt_q == 3'h1)
                    begin
                        cnt_d = 3'h0;
                        st_d = ST_SYNC;
                    end
                end
                ST_SYNC:
                begin
                    cnt_d = cnt_q + 3'h1;
                    if (cnt_q == 3'(`NL_SYNC_CYCLES - 3'h1))
                    begin
                        cnt_d = 3'h0;
                        if (!we_q)
                            data_d = mem_rdata;
                        st_d = we_q ? ST_STAR : ST_RDATA;
                    end
                end
                ST_RDATA:
                begin
                    data_d = {4'h0, data_q[15:4]};
                    cnt_d = cnt_q + 3'h1;
                    if (cnt_q == 3'h3)
                    begin
                        cnt_d = 3'h0;
                        st_d = ST_STAR;
                    end
                end
                ST_STAR:
                begin
                    cnt_d = cnt_q + 3'h1;
                    if (cnt_q == 3'h1)
                    begin
                        cnt_d = 3'h0;
                        st_d = ST_IDLE;
                    end
                end
                default: st_d = ST_IDLE;
            endcase
        end
    end

    // State registers on the link clock.
    // Only constants are loaded in reset, so the release is clean.
    always_ff @(posedge link.link_clk or posedge rst)
    begin
        if (rst)
        begin
            st_q <= ST_IDLE;
            cnt_q <= 3'h0;
            we_q <= 1'b0;
            addr_q <= 16'h0000;
            data_q <= 16'h0000;
            perr_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            we_q <= we_d;
            addr_q <= addr_d;
            data_q <= data_d;
            perr_q <= perr_d;
        end
    end

    //----------------------------------------------------------------
    // Bus drive onto the shared link
    //----------------------------------------------------------------

    // Slave drives sync, read data and its first turnaround cycle only.
    // Outside those cycles the slave releases the bus to the master or the pull-ups.
    always_comb
    begin
        link.s_bus_oe = 1'b0;
        link.s_bus_out = 5'h1f;
        if (st_q == ST_SYNC)
        begin
            link.s_bus_oe = 1'b1;
            link.s_bus_out[3:0] = (cnt_q == 3'(`NL_SYNC_CYCLES - 3'h1)) ?
                `NL_NIB_READY : `NL_NIB_WAIT;
        end
        else if (st_q == ST_RDATA)
        begin
            link.s_bus_oe = 1'b1;
            link.s_bus_out[3:0] = data_q[3:0];
        end
        else if (st_q == ST_STAR && cnt_q == 3'h0)
        begin
            link.s_bus_oe = 1'b1;
            link.s_bus_out[3:0] = `NL_NIB_TAR;
        end
        link.s_bus_out[4] = ^link.s_bus_out[3:0];
    end

    //----------------------------------------------------------------
    // Memory side and interrupt
    //----------------------------------------------------------------

    // Memory strobe in the first sync cycle; read data sampled at the end of the last.
    // The memory therefore has three link cycles to answer a read, since
    // the sync phase is a fixed four cycles long.
    assign mem_req = (st_q == ST_SYNC) && (cnt_q == 3'h0);
    assign mem_we = we_q;
    assign mem_addr = addr_q;
    assign mem_wdata = data_q;

    // Parity error is a one-cycle pulse per bad master nibble from start through write data; the turnaround nibble is not checked.
    assign parity_err = perr_q;

    // Interrupt line is a level, held low while a request is pending.
    assign link.irq_n = !irq_pending;
endmodule

// File: sim/nibble_link_props.sv
// Assertions watching the wires of the simplified nibble link.
`timescale 1ns/100ps
module nibble_link_props (
    input wire logic link_clk,
    input wire logic rst,
    input wire logic frame_n,
    input wire logic [4:0] m_bus_out,
    input wire logic m_bus_oe,
    input wire logic [4:0] s_bus_out,
    input wire logic s_bus_oe
);
    // All checks run on the link clock and rest while reset is high.
    default clocking cb @(posedge link_clk);
    endclocking
    default disable iff (rst);

    // A nibble driven by the master or by the slave with a given value.
    sequence m_is(logic [3:0] v);
        m_bus_oe && m_bus_out[3:0] == v;
    endsequence
    sequence s_is(logic [3:0] v);
        s_bus_oe && s_bus_out[3:0] == v;
    endsequence

    // Parity, ownership and framing of every transaction.
    a_m_parity: assert property (m_bus_oe |-> !(^m_bus_out))
        else $error("Master nibble has odd parity.");
    a_s_parity: assert property (s_bus_oe |-> !(^s_bus_out))
        else $error("Slave nibble has odd parity.");
    a_one_driver: assert property (!(m_bus_oe && s_bus_oe))
        else $error("Both ends drive the bus.");
    a_start_zero: assert property (!frame_n |-> m_is(4'h0))
        else $error("Start cycle does not carry zero.");
    a_frame_once: assert property (!frame_n |=> frame_n [*8])
        else $error("Frame strobe stays low after the start cycle.");
    a_type_ok: assert property (!frame_n
        |=> m_is(4'h4) or m_is(4'h6))
        else $error("Unknown cycle type sent.");
    a_slave_quiet: assert property (!frame_n |=> !s_bus_oe [*7])
        else $error("Slave drives before its turn.");
    a_read_walk: assert property (!frame_n ##1 m_is(4'h4)
        |-> ##5 m_is(4'hf) ##1 !m_bus_oe && !s_bus_oe ##1 s_is(4'h5) [*3]
        ##1 s_is(4'h0) ##1 s_bus_oe [*4] ##1 s_is(4'hf) ##1 !s_bus_oe)
        else $error("Read frame out of order.");
    a_write_walk: assert property (!frame_n ##1 m_is(4'h6)
        |-> ##1 m_bus_oe [*8] ##1 m_is(4'hf) ##1 !m_bus_oe && !s_bus_oe
        ##1 s_is(4'h5) [*3] ##1 s_is(4'h0) ##1 s_is(4'hf) ##1 !s_bus_oe)
        else $error("Write frame out of order.");

    // Main scenarios seen on the wire.
    c_read: cover property (!frame_n ##1 m_is(4'h4));
    c_write: cover property (!frame_n ##1 m_is(4'h6));
    c_wait: cover property (s_is(4'h5) ##1 s_is(4'h5));
endmodule

// File: sim/test_nibble_bus_memory_slave.sv
// Bench joining both link ends, with a faulty master on a second link.
`timescale 1ns/100ps
module test_nibble_bus_memory_slave;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    logic req_we = 1'b0;
    logic [15:0] req_addr = 16'h0000;
    logic [31:0] req_wdata = 32'h0000_0000;
    logic [15:0] mem_rdata = 16'h0000;
    logic irq_pending = 1'b0;
    logic req_ready, done, irq, m_perr, s_perr, s2_perr;
    logic mem_req, mem_we, mem_req2, mem_we2;
    logic [15:0] mem_addr, mem_wdata, mem_addr2, mem_wdata2;
    logic [15:0] cap_addr, cap_data;
    logic [31:0] rdata;
    logic [15:0] mem_table [0:65535];
    logic [15:0] addr_log [$];
    logic [4:0] wire_log [0:17];
    int wire_idx = 18;
    int n_errors = 0;
    int samples_checked = 0;
    int n_perr2 = 0;
    int n_req2 = 0;
    int n_drive2 = 0;
    logic [15:0] wr_addr [0:2] = '{16'h0000, 16'hfffc, 16'h5a5b};
    logic [31:0] wr_data [0:2] =
        '{32'h1234_5678, 32'h89ab_cdef, 32'hc3a5_0f96};
    nibble_link_if link ();
    nibble_link_if bad_link ();

    // System clock, 8 ns period.
    always #4 clk = ~clk;

    nibble_link_master nibble_link_master_i (
        .clk(clk), .rst(rst), .link(link), .req_valid(req_valid),
        .req_ready(req_ready), .req_we(req_we), .req_addr(req_addr),
        .req_wdata(req_wdata), .done(done), .rdata(rdata), .irq(irq),
        .parity_err(m_perr));
    nibble_link_slave nibble_link_slave_i (
        .link(link), .rst(rst), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .irq_pending(irq_pending), .parity_err(s_perr));
    nibble_link_slave nibble_link_slave_i2 (
        .link(bad_link), .rst(rst), .mem_req(mem_req2), .mem_we(mem_we2),
        .mem_addr(mem_addr2), .mem_wdata(mem_wdata2), .mem_rdata(16'h0000),
        .irq_pending(1'b0), .parity_err(s2_perr));
    nibble_link_props nibble_link_props_i (
        .link_clk(link.link_clk), .rst(rst), .frame_n(link.frame_n),
        .m_bus_out(link.m_bus_out), .m_bus_oe(link.m_bus_oe),
        .s_bus_out(link.s_bus_out), .s_bus_oe(link.s_bus_oe));

    // Memory behind the slave on the link clock; logs each request.
    always @(posedge link.link_clk)
    begin
        if (mem_req === 1'b1)
        begin
            addr_log.push_back(mem_addr);
            if (mem_we === 1'b1)
                mem_table[mem_addr] = mem_wdata;
        end
        mem_rdata <= mem_table[mem_addr];
    end

    // Records the wire of the latest frame at the slave's sampling edge.
    always @(posedge link.link_clk)
    begin
        if (link.frame_n === 1'b0)
            wire_idx = 0;
        if (wire_idx < 18)
        begin
            wire_log[wire_idx] = link.bus_in;
            wire_idx++;
        end
    end

    // Counts what the second slave does under the faulty master.
    always @(negedge bad_link.link_clk)
    begin
        n_perr2 += (s2_perr === 1'b1);
        n_drive2 += (bad_link.s_bus_oe === 1'b1);
        if (mem_req2 === 1'b1)
        begin
            n_req2++;
            cap_addr = mem_addr2;
            cap_data = mem_wdata2;
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h, expected %h",
                $time, got, exp);
        end
    endtask

    task automatic give_verdict;
        $display("errors %0d, checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // One 32-bit user access; the request is held until it is taken.
    task automatic access(input logic we, input logic [15:0] a,
        input logic [31:0] wd);
        int i;
        req_valid = 1'b1;
        req_we = we;
        req_addr = a;
        req_wdata = wd;
        for (i = 0; i < 50 && req_ready !== 1'b1; i++)
            @(negedge clk);
        @(negedge clk);
        req_valid = 1'b0;
        for (i = 0; i < 1000 && done !== 1'b1; i++)
            @(negedge clk);
        if (done !== 1'b1)
        begin
            n_errors++;
            give_verdict();
        end
        else
            repeat (8) @(negedge clk);
    endtask

    // One link cycle of the faulty master, 80 ns, clock low between frames.
    task automatic bad_cycle(input logic fr, input logic oe,
        input logic [3:0] nib, input logic flip);
        bad_link.frame_n = fr;
        bad_link.m_bus_oe = oe;
        bad_link.m_bus_out = {(^nib) ^ flip, nib};
        #40 bad_link.link_clk = 1'b1;
        #40 bad_link.link_clk = 1'b0;
    endtask

    // Whole write-shaped frame; flip_at marks a nibble with bad parity.
    task automatic bad_frame(input logic [3:0] ty, input logic [15:0] a,
        input logic [15:0] d, input int flip_at);
        logic [3:0] nibs [0:10];
        int k;
        nibs = '{4'h0, ty, a[15:12], a[11:8], a[7:4], a[3:0],
            d[3:0], d[7:4], d[11:8], d[15:12], 4'hf};
        n_perr2 = 0;
        n_req2 = 0;
        n_drive2 = 0;
        for (k = 0; k < 18; k++)
            bad_cycle(k != 0, k < 11, k < 11 ? nibs[k] : 4'hf, k == flip_at);
    endtask

    // Main sequence: writes, reads back, interrupt, faulty master.
    initial
    begin
        int i;
        int j;
        logic [15:0] a;
        logic [15:0] b;
        bad_link.link_clk = 1'b0;
        bad_link.frame_n = 1'b1;
        bad_link.m_bus_oe = 1'b0;
        bad_link.m_bus_out = 5'h1f;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        for (i = 0; i < 3; i++)
        begin
            a = wr_addr[i] & 16'hfffc;
            b = a + 16'h0002;
            addr_log.delete();
            access(1'b1, wr_addr[i], wr_data[i]);
            check(32'(addr_log.size()), 32'h2);
            check({addr_log[0], addr_log[1]}, {a, b});
            check({mem_table[b], mem_table[a]}, wr_data[i]);
            check(wire_log[1][3:0], 4'h6);
            for (j = 0; j < 4; j++)
            begin
                check({wire_log[2 + j][3:0], wire_log[6 + j][3:0]},
                    {b[15 - 4 * j -: 4], wr_data[i][16 + 4 * j +: 4]});
                check({^wire_log[2 + j], ^wire_log[6 + j]}, 2'b00);
            end
        end
        for (i = 0; i < 3; i++)
        begin
            access(1'b0, wr_addr[i], 32'h0000_0000);
            check(rdata, wr_data[i]);
            check(wire_log[1][3:0], 4'h4);
            check({wire_log[7], wire_log[8][3:0], wire_log[11][3:0]},
                {5'h1f, 4'h5, 4'h0});
            for (j = 0; j < 4; j++)
                check(wire_log[12 + j][3:0], wr_data[i][16 + 4 * j +: 4]);
            check({wire_log[16], wire_log[17]}, {5'h0f, 5'h1f});
        end
        check({m_perr, s_perr}, 2'b00);
        irq_pending = 1'b1;
        repeat (4) @(negedge clk);
        check({irq, link.irq_n}, 2'b10);
        irq_pending = 1'b0;
        repeat (4) @(negedge clk);
        check({irq, link.irq_n}, 2'b01);
        bad_frame(4'h2, 16'h1111, 16'h2222, 99);
        check(32'(n_req2 + n_drive2), 32'h0);
        bad_frame(4'h6, 16'h3c5a, 16'h9f17, 99);
        check({cap_addr, cap_data}, 32'h3c5a_9f17);
        check(32'(n_req2 * 256 + n_drive2 * 16 + n_perr2), 32'h150);
        bad_frame(4'h6, 16'h0f0f, 16'h0000, 3);
        check(32'(n_perr2 > 0), 32'h1);
        give_verdict();
    end
endmodule
